// >>> verilog/mrs_cfg.svh
// Purpose: Constants of the RTU slave frame handler
// Assumes: Included by bare name where needed
// Notes: Definitions only
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH
// ==========================================================
// Function codes and exception codes
`define MRS_FC_READ 8'h03
`define MRS_FC_WR1 8'h06
`define MRS_FC_WRN 8'h10
`define MRS_EXC_FLAG 8'h80
`define MRS_EXC_ILL_FUNC 8'h01
`define MRS_EXC_ILL_VAL 8'h03
// ==========================================================
// Checksum
`define MRS_CRC_INIT 16'hffff
`define MRS_CRC_POLY 16'ha001
// ==========================================================
// Frame layout
`define MRS_MAX_REGS 32
`define MRS_BUF_LEN 80
`define MRS_REQ_LEN 8
`define MRS_WRN_HDR 9
`define MRS_WR_RSP_LEN 6
`define MRS_RD_HDR 3
`define MRS_WR1_DBASE 4
`define MRS_WRN_DBASE 7
// ==========================================================
// Timing: silence of 5000 us at the reference baud rate
`define MRS_CLK_MHZ 250
`define MRS_REF_BAUD 9600
`define MRS_SILENCE_US 5000
`endif

// >>> verilog/mrs_pkg.sv
// Purpose: Types of the RTU slave frame handler
// Assumes: Nothing
// Notes: Constants live in mrs_cfg.svh
`default_nettype none
package mrs_pkg;
  // ========================================================
  // Handler states, one-hot
  typedef enum logic [6:0] {
    ST_RX = 7'h01,
    ST_CHECK = 7'h02,
    ST_EXEC = 7'h04,
    ST_RD = 7'h08,
    ST_RDW = 7'h10,
    ST_WR = 7'h20,
    ST_SEND = 7'h40
  } mrs_state_t;
  // Byte stream toward the serializer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mrs_tx_t;
  // Request toward the register map
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mrs_reg_req_t;
endpackage : mrs_pkg
`default_nettype wire

// >>> verilog/mrs_crc_step.sv
// Purpose: One byte step of the reflected 16-bit checksum
// Assumes: Combinational, caller registers the result
// Notes: Eight shift and conditional xor rounds
`timescale 1ns/100ps
`default_nettype none
module mrs_crc_step #(
  parameter logic [15:0] POLY = 16'ha001
) (
  input wire logic [15:0] crc_i,
  input wire logic [7:0] data_i,
  output logic [15:0] crc_o
);
  // ========================================================
  // Byte xor then eight shifts toward the LSB
  always_comb begin
    logic [15:0] c;
    c = crc_i ^ {8'h00, data_i};
    for (int b = 0; b < 8; b++) begin
      // Xor the constant when the dropped bit was one
      if (c[0]) begin
        c = (c >> 1) ^ POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_o = c;
  end
endmodule : mrs_crc_step
`default_nettype wire

// >>> verilog/mrs_frame.sv
// Purpose: RTU slave frame handler, receive, check, execute, reply
// Assumes: Byte stream in and out at the character layer
// Notes: Silence timer sets frame ends and reply turnaround
// Function
// - Characters are 8N1 asynchronous bytes
// - Sender keeps 3.5 character silence first
// - 3.5 character silence ends the message
// - Frame bytes go back to back
// - Long silence flushes a partial frame
// - Early byte appends, then fails checksum
// - Silence near 5 ms at 9600, scaled
// - First byte is address 1 to 255
// - Act only on own address, else silent
// - Reply starts with own address
// - Execute only codes 03, 06, 10
// - Read reply: count 2n, data, checksum
// - Write single stores one register value
// - Write single echoes address and data
// - Write multiple: n 1..32, 2n bytes
// - Write multiple replies start and count
// - Failing request returns exception reply
// - Checksum from all ones, shift xor
// - Checksum mismatch is an error
`timescale 1ns/100ps
`default_nettype none
`include "mrs_cfg.svh"
module mrs_frame #(
  parameter int unsigned BAUD = `MRS_REF_BAUD,
  // Silence in cycles, derived from time, clock and baud
  parameter longint unsigned SILENCE_CYC = (64'(`MRS_SILENCE_US) * 64'(`MRS_CLK_MHZ)
    * 64'(`MRS_REF_BAUD)) / 64'(BAUD),
  parameter int CW = 24,
  parameter int MAXN = `MRS_MAX_REGS,
  parameter int BUF_LEN = `MRS_BUF_LEN
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] slave_addr_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic tx_ready_i,
  input wire logic [15:0] reg_rd_data_i,
  output mrs_pkg::mrs_tx_t tx_o,
  output mrs_pkg::mrs_reg_req_t reg_o,
  output logic crc_err_o
);
  // ========================================================
  // Local constants and state
  localparam logic [CW-1:0] SIL_M1 = CW'(SILENCE_CYC - 64'd1);
  typedef logic [BUF_LEN-1:0][7:0] mrs_buf_t;
  typedef struct packed {
    mrs_pkg::mrs_state_t st; // Handler state
    logic [7:0] len;         // Bytes held in the buffer
    logic [7:0] idx;         // Walk index
    logic [CW-1:0] cnt;      // Silence timer
    logic ovf;               // Frame overran the buffer
    logic [15:0] crc_rx;     // Running receive checksum
    logic [15:0] crc_tx;     // Running send checksum
    logic [15:0] start;      // First register address
    logic [5:0] nreg;        // Registers to move
    logic [7:0] dbase;       // Offset of write data
    mrs_buf_t buff;          // Frame buffer
    mrs_pkg::mrs_tx_t tx;    // Outgoing byte
    mrs_pkg::mrs_reg_req_t rq; // Register request
    logic crc_err;           // Error pulse
  } mrs_st_t;
  mrs_st_t s_r;
  mrs_st_t s_nxt;
  logic [15:0] crc_rx_step; // Receive checksum after this byte
  logic [15:0] crc_tx_step; // Send checksum after next byte
  logic [7:0] tx_byte;      // Next buffered byte to send
  // ========================================================
  // Buffer word helper, fields travel high byte first
  function automatic logic [15:0] word_at(input mrs_buf_t b, input logic [7:0] i);
    word_at = {b[i], b[i + 8'h01]};
  endfunction : word_at
  // ========================================================
  // Checksum steppers
  mrs_crc_step #(.POLY(`MRS_CRC_POLY)) u_crc_rx (
    .crc_i(s_r.crc_rx),
    .data_i(rx_data_i),
    .crc_o(crc_rx_step)
  );
  assign tx_byte = (s_r.idx < 8'(BUF_LEN)) ? s_r.buff[s_r.idx] : 8'h00;
  mrs_crc_step #(.POLY(`MRS_CRC_POLY)) u_crc_tx (
    .crc_i(s_r.crc_tx),
    .data_i(tx_byte),
    .crc_o(crc_tx_step)
  );
  // ========================================================
  // Next state logic
  always_comb begin
    logic [15:0] n16;
    logic nok;
    logic [7:0] n2;
    n16 = word_at(s_r.buff, 8'h04);
    nok = (n16 != 16'h0000) && (n16 <= 16'(MAXN));
    n2 = {n16[6:0], 1'b0};
    s_nxt = s_r;
    s_nxt.rq.rd = 1'b0;
    s_nxt.rq.wr = 1'b0;
    s_nxt.crc_err = 1'b0;
    unique case (s_r.st)
      // Collect bytes until the line falls silent
      mrs_pkg::ST_RX: begin
        if (rx_valid_i) begin
          s_nxt.cnt = '0;
          // Early byte joins the open frame
          if (s_r.len < 8'(BUF_LEN)) begin
            s_nxt.buff[s_r.len] = rx_data_i; // Whole character
            s_nxt.len = s_r.len + 8'h01;
            s_nxt.crc_rx = crc_rx_step;
          end else begin
            s_nxt.ovf = 1'b1;
          end
        end else if (s_r.len != 8'h00) begin
          // Silence closes the message
          if (s_r.cnt == SIL_M1) begin
            s_nxt.st = mrs_pkg::ST_CHECK;
          end else begin
            s_nxt.cnt = s_r.cnt + CW'(1);
          end
        end
      end
      // Screen checksum and address
      mrs_pkg::ST_CHECK: begin
        // Residue zero means the checksum matched
        if (s_r.ovf || s_r.len < 8'h04 || s_r.crc_rx != 16'h0000) begin
          s_nxt.crc_err = 1'b1;
          s_nxt.st = mrs_pkg::ST_RX;
        end else if (s_r.buff[0] != slave_addr_i || s_r.buff[0] == 8'h00) begin
          // Not ours or address zero, stay silent
          s_nxt.st = mrs_pkg::ST_RX;
        end else begin
          s_nxt.st = mrs_pkg::ST_EXEC;
        end
        // Flushed frames restart the buffer
        if (s_nxt.st == mrs_pkg::ST_RX) begin
          s_nxt.len = 8'h00;
          s_nxt.ovf = 1'b0;
          s_nxt.crc_rx = `MRS_CRC_INIT;
        end
      end
      // Decode the function code
      mrs_pkg::ST_EXEC: begin
        s_nxt.idx = 8'h00;
        s_nxt.start = word_at(s_r.buff, 8'h02);
        s_nxt.st = mrs_pkg::ST_SEND;
        s_nxt.len = 8'(`MRS_RD_HDR);
        s_nxt.buff[1] = s_r.buff[1] | `MRS_EXC_FLAG;
        s_nxt.buff[2] = `MRS_EXC_ILL_VAL;
        unique case (s_r.buff[1])
          // Read: start and count
          `MRS_FC_READ: begin
            if (s_r.len == 8'(`MRS_REQ_LEN) && nok) begin
              s_nxt.nreg = n16[5:0];
              s_nxt.buff[1] = s_r.buff[1];
              s_nxt.buff[2] = n2;
              s_nxt.st = mrs_pkg::ST_RD;
            end
          end
          // Write single
          `MRS_FC_WR1: begin
            if (s_r.len == 8'(`MRS_REQ_LEN)) begin
              s_nxt.nreg = 6'h01;
              s_nxt.dbase = 8'(`MRS_WR1_DBASE);
              s_nxt.buff[1] = s_r.buff[1];
              s_nxt.buff[2] = s_r.buff[2];
              s_nxt.st = mrs_pkg::ST_WR;
            end
          end
          // Write multiple, count and byte count agree
          `MRS_FC_WRN: begin
            if (nok && s_r.buff[6] == n2 && s_r.len == 8'(`MRS_WRN_HDR) + n2) begin
              s_nxt.nreg = n16[5:0];
              s_nxt.dbase = 8'(`MRS_WRN_DBASE);
              s_nxt.buff[1] = s_r.buff[1];
              s_nxt.buff[2] = s_r.buff[2];
              s_nxt.st = mrs_pkg::ST_WR;
            end
          end
          // Unknown code, flagged exception
          default: begin
            s_nxt.buff[2] = `MRS_EXC_ILL_FUNC;
          end
        endcase
      end
      // Fetch one register
      mrs_pkg::ST_RD: begin
        s_nxt.rq.rd = 1'b1;
        s_nxt.rq.addr = s_r.start + 16'(s_r.idx);
        s_nxt.st = mrs_pkg::ST_RDW;
      end
      // Capture register data high byte first
      mrs_pkg::ST_RDW: begin
        s_nxt.buff[8'(`MRS_RD_HDR) + {s_r.idx[6:0], 1'b0}] = reg_rd_data_i[15:8];
        s_nxt.buff[8'(`MRS_RD_HDR) + {s_r.idx[6:0], 1'b1}] = reg_rd_data_i[7:0];
        s_nxt.idx = s_r.idx + 8'h01;
        s_nxt.st = mrs_pkg::ST_RD;
        if (s_r.idx + 8'h01 == {2'b00, s_r.nreg}) begin
          s_nxt.len = 8'(`MRS_RD_HDR) + {1'b0, s_r.nreg, 1'b0};
          s_nxt.idx = 8'h00;
          s_nxt.st = mrs_pkg::ST_SEND;
        end
      end
      // Store registers one per cycle
      mrs_pkg::ST_WR: begin
        if (s_r.idx < {2'b00, s_r.nreg}) begin
          s_nxt.rq.wr = 1'b1;
          s_nxt.rq.addr = s_r.start + 16'(s_r.idx);
          s_nxt.rq.wdata = word_at(s_r.buff, s_r.dbase + {s_r.idx[6:0], 1'b0});
          s_nxt.idx = s_r.idx + 8'h01;
        end else begin
          // Echo address, function, start and count or data
          s_nxt.len = 8'(`MRS_WR_RSP_LEN);
          s_nxt.idx = 8'h00;
          s_nxt.st = mrs_pkg::ST_SEND;
        end
      end
      // Stream the reply, silence already elapsed
      mrs_pkg::ST_SEND: begin
        // Next byte as soon as the last is taken
        if (!s_r.tx.valid || tx_ready_i) begin
          s_nxt.tx.valid = 1'b1;
          s_nxt.idx = s_r.idx + 8'h01;
          if (s_r.idx < s_r.len) begin
            // Buffer byte 0 holds our own address
            s_nxt.tx.data = tx_byte;
            s_nxt.crc_tx = crc_tx_step;
          end else if (s_r.idx == s_r.len) begin
            s_nxt.tx.data = s_r.crc_tx[7:0];
          end else if (s_r.idx == s_r.len + 8'h01) begin
            s_nxt.tx.data = s_r.crc_tx[15:8];
          end else begin
            // Reply done, reopen the receiver
            s_nxt.tx.valid = 1'b0;
            s_nxt.st = mrs_pkg::ST_RX;
            s_nxt.len = 8'h00;
            s_nxt.cnt = '0;
            s_nxt.crc_rx = `MRS_CRC_INIT;
            s_nxt.crc_tx = `MRS_CRC_INIT;
          end
        end
      end
    endcase
  end
  // ========================================================
  // State register with clock enable
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
      s_r.st <= mrs_pkg::ST_RX;
      s_r.crc_rx <= `MRS_CRC_INIT;
      s_r.crc_tx <= `MRS_CRC_INIT;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end
  // ========================================================
  // Outputs straight from the state register
  assign tx_o = s_r.tx;
  assign reg_o = s_r.rq;
  assign crc_err_o = s_r.crc_err;
  // ========================================================
  // Checks
  property p_eof;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && s_r.st == mrs_pkg::ST_RX && s_r.len != 8'h00 && !rx_valid_i
      && s_r.cnt == SIL_M1) |=> (s_r.st == mrs_pkg::ST_CHECK);
  endproperty
  a_eof: assert property (p_eof) else $error("Silence did not end frame");
  property p_append;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && s_r.st == mrs_pkg::ST_RX && rx_valid_i && s_r.len < 8'(BUF_LEN))
      |=> (s_r.len == $past(s_r.len) + 8'h01 && s_r.cnt == '0);
  endproperty
  a_append: assert property (p_append) else $error("Byte not appended");
  property p_flush;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && s_r.st == mrs_pkg::ST_CHECK && s_r.crc_rx != 16'h0000)
      |=> (crc_err_o && s_r.st == mrs_pkg::ST_RX && s_r.len == 8'h00);
  endproperty
  a_flush: assert property (p_flush) else $error("Bad frame not flushed");
  property p_addr;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && s_r.st == mrs_pkg::ST_CHECK && s_r.buff[0] != slave_addr_i)
      |=> (s_r.st == mrs_pkg::ST_RX);
  endproperty
  a_addr: assert property (p_addr) else $error("Foreign frame acted on");
  property p_first;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (s_r.st == mrs_pkg::ST_SEND && tx_o.valid && s_r.idx == 8'h01)
      |-> (tx_o.data == slave_addr_i);
  endproperty
  a_first: assert property (p_first) else $error("Reply not led by own address");
  property p_badfc;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && s_r.st == mrs_pkg::ST_EXEC && s_r.buff[1] != `MRS_FC_READ
      && s_r.buff[1] != `MRS_FC_WR1 && s_r.buff[1] != `MRS_FC_WRN)
      |=> (s_r.buff[1][7] && s_r.buff[2] == `MRS_EXC_ILL_FUNC && s_r.len == 8'h03);
  endproperty
  a_badfc: assert property (p_badfc) else $error("No exception for bad code");
  property p_rdlen;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (s_r.st == mrs_pkg::ST_SEND && s_r.buff[1] == `MRS_FC_READ)
      |-> (s_r.buff[2] == {1'b0, s_r.nreg, 1'b0} && s_r.len == s_r.buff[2] + 8'h03);
  endproperty
  a_rdlen: assert property (p_rdlen) else $error("Read reply length wrong");
  property p_wrlen;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (s_r.st == mrs_pkg::ST_SEND && !s_r.buff[1][7] && s_r.buff[1] != `MRS_FC_READ)
      |-> (s_r.len == 8'h06);
  endproperty
  a_wrlen: assert property (p_wrlen) else $error("Write reply length wrong");
  property p_wrstrobe;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    reg_o.wr |-> (reg_o.addr == s_r.start + 16'(s_r.idx) - 16'h0001);
  endproperty
  a_wrstrobe: assert property (p_wrstrobe) else $error("Write address wrong");
  c_read: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_r.st == mrs_pkg::ST_RDW ##1 s_r.st == mrs_pkg::ST_SEND);
  c_wrn: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    reg_o.wr && s_r.buff[1] == `MRS_FC_WRN ##1 reg_o.wr);
  c_exc: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_r.st == mrs_pkg::ST_SEND && s_r.buff[1][7]);
  c_crc: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) crc_err_o);
endmodule : mrs_frame
`default_nettype wire

// >>> tb/mrs_host_model.sv
// Purpose: Far side model: register map and serializer sink
// Assumes: Register reads are combinational from the address
// Notes: Stalls the byte sink at random when slow_i is high
`timescale 1ns/100ps
`default_nettype none
module mrs_host_model (
  input wire logic core_clk_i,
  input wire logic slow_i,
  input wire mrs_pkg::mrs_reg_req_t reg_i,
  output logic tx_ready_o,
  output logic [15:0] rd_data_o
);
  logic [15:0] mem[256]; // Register contents, low address byte only
  // ==========================================================
  // Known start contents, mirrored by the bench shadow
  initial begin
    foreach (mem[i]) mem[i] = 16'h3c00 + 16'(i);
    tx_ready_o = 1'b1;
  end
  // Read data only valid under the read strobe
  assign rd_data_o = reg_i.rd ? mem[reg_i.addr[7:0]] : ~mem[reg_i.addr[7:0]];
  // Store a written word
  always @(posedge core_clk_i) begin
    if (reg_i.wr === 1'b1) mem[reg_i.addr[7:0]] <= reg_i.wdata;
  end
  // Byte sink takes whole characters, stalling when slow
  always @(negedge core_clk_i) begin
    tx_ready_o <= slow_i ? 1'($urandom) : 1'b1;
  end
endmodule : mrs_host_model
`default_nettype wire

// >>> tb/mrs_frame_bench.sv
// Purpose: Self-checking bench of the RTU slave frame handler
// Assumes: Silence shortened to SIL cycles
// Notes: Drivers queue expected results, a monitor pops them
`timescale 1ns/100ps
`default_nettype none
module mrs_frame_bench;
  localparam int SIL = 40; // Shortened silence
  logic core_clk_i = 1'b0; // 250 MHz clock
  logic sys_rst_i = 1'b1; // Sync reset
  logic rx_valid_i = 1'b0; // Byte strobe
  logic [7:0] rx_data_i = 8'h00; // Received byte
  logic [7:0] own = 8'h01; // Own slave address
  logic slow = 1'b0; // Far side stalls
  logic ce = 1'b1; // Clock enable, frozen in one scenario
  logic tx_ready_i;
  logic [15:0] reg_rd_data_i;
  mrs_pkg::mrs_tx_t tx_o;
  mrs_pkg::mrs_reg_req_t reg_o;
  logic crc_err_o;
  logic [8:0] exp_q[$]; // Stream notes, 9'h100 is a checksum error
  logic [31:0] wr_q[$]; // Write notes, address and data
  logic [15:0] shadow[256]; // Expected register contents
  int failures = 0;
  int cmp_count = 0;
  int quiet = 0; // Cycles since the last received byte
  logic tx_was = 1'b0; // Valid one cycle ago
  // ==========================================================
  // Clock and instances
  always #2 core_clk_i = ~core_clk_i;
  mrs_frame #(.SILENCE_CYC(SIL)) mrs_frame_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce), .slave_addr_i(own), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .tx_ready_i(tx_ready_i), .reg_rd_data_i(reg_rd_data_i), .tx_o(tx_o), .reg_o(reg_o),
    .crc_err_o(crc_err_o));
  mrs_host_model mrs_host_model_i (.core_clk_i(core_clk_i), .slow_i(slow), .reg_i(reg_o),
    .tx_ready_o(tx_ready_i), .rd_data_o(reg_rd_data_i));
  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check
  // One compare task per kind of result
  task automatic cmp_byte(input logic [8:0] e, input logic [8:0] g);
    check("stream", 32'(e), 32'(g));
  endtask : cmp_byte
  task automatic cmp_err(input logic [8:0] e);
    check("error pulse", 32'(e), 32'h100);
  endtask : cmp_err
  task automatic cmp_write(input logic [31:0] e, input logic [31:0] g);
    check("write", e, g);
  endtask : cmp_write
  // Reflected checksum, all ones start
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
    end
    return c;
  endfunction : crc
  // Send bytes back to back; seal 1 good checksum, 2 corrupted
  task automatic send(input logic [7:0] q[$], input logic [1:0] seal);
    logic [15:0] c;
    c = crc(q) ^ ((seal == 2'd2) ? 16'h0001 : 16'h0000);
    if (seal != 2'd0) begin
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
    end
    foreach (q[i]) begin
      @(negedge core_clk_i);
      rx_valid_i = 1'b1;
      rx_data_i = q[i];
    end
    @(negedge core_clk_i);
    rx_valid_i = 1'b0;
  endtask : send
  // Note a reply, checksum appended low byte first
  task automatic expect_reply(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc(q);
    foreach (q[i]) exp_q.push_back({1'b0, q[i]});
    exp_q.push_back({1'b0, c[7:0]});
    exp_q.push_back({1'b0, c[15:8]});
  endtask : expect_reply
  // Wait out silence and reply, all notes must be used
  task automatic settle();
    int n;
    n = 0;
    repeat (SIL + 4) @(negedge core_clk_i);
    while ((exp_q.size() != 0 || tx_o.valid !== 1'b0) && n < 3000) begin
      @(negedge core_clk_i);
      n++;
    end
    repeat (4) @(negedge core_clk_i);
    check("pending notes", 0, exp_q.size() + wr_q.size());
  endtask : settle
  task automatic rd(input logic [15:0] s, input logic [7:0] n);
    logic [7:0] r[$];
    r = '{own, 8'h03, 8'h02 * n};
    for (int k = 0; k < n; k++) begin
      r.push_back(shadow[8'(s + k)][15:8]);
      r.push_back(shadow[8'(s + k)][7:0]);
    end
    expect_reply(r);
    send('{own, 8'h03, s[15:8], s[7:0], 8'h00, n}, 2'd1);
    settle();
  endtask : rd
  task automatic wr1(input logic [15:0] a, input logic [15:0] d);
    wr_q.push_back({a, d});
    shadow[a[7:0]] = d;
    expect_reply('{own, 8'h06, a[15:8], a[7:0], d[15:8], d[7:0]});
    send('{own, 8'h06, a[15:8], a[7:0], d[15:8], d[7:0]}, 2'd1);
    settle();
  endtask : wr1
  task automatic wrn(input logic [15:0] s, input logic [7:0] n);
    logic [7:0] q[$];
    logic [15:0] d;
    q = '{own, 8'h10, s[15:8], s[7:0], 8'h00, n, 8'h02 * n};
    for (int k = 0; k < n; k++) begin
      d = 16'($urandom);
      q.push_back(d[15:8]);
      q.push_back(d[7:0]);
      wr_q.push_back({16'(s + k), d});
      shadow[8'(s + k)] = d;
    end
    expect_reply('{own, 8'h10, s[15:8], s[7:0], 8'h00, n});
    send(q, 2'd1);
    settle();
  endtask : wrn
  // Exception reply: flagged code and fault code
  task automatic exc(input logic [7:0] q[$], input logic [7:0] fc, input logic [7:0] code);
    expect_reply('{own, fc, code});
    send(q, 2'd1);
    settle();
  endtask : exc
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Monitor: pops notes as results appear
  always @(posedge core_clk_i) begin
    quiet <= rx_valid_i ? 0 : quiet + 1;
    tx_was <= tx_o.valid;
    if (!sys_rst_i) begin
      if (tx_o.valid === 1'b1 && tx_was === 1'b0)
        check("turnaround", 1, quiet >= SIL);
      if (tx_o.valid === 1'b1 && tx_ready_i === 1'b1)
        cmp_byte((exp_q.size() != 0) ? exp_q.pop_front() : 9'h1ff, {1'b0, tx_o.data});
      if (crc_err_o === 1'b1)
        cmp_err((exp_q.size() != 0) ? exp_q.pop_front() : 9'h1ff);
      if (reg_o.wr === 1'b1)
        cmp_write((wr_q.size() != 0) ? wr_q.pop_front() : 32'hx,
          {reg_o.addr, reg_o.wdata});
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    wrap_up();
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(40217));
    own = 8'h01 + 8'($urandom % 255);
    foreach (shadow[i]) shadow[i] = 16'h3c00 + 16'(i);
    repeat (2) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    rd(16'h0002, 8'd2);
    wr1(16'h0005, 16'($urandom));
    wrn(16'h0008, 8'd3);
    slow = 1'b1;
    rd(16'h0004, 8'd8);
    wrn(16'h0020, 8'd32);
    slow = 1'b0;
    rd(16'h0020, 8'd32);
    exc('{own, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h84, 8'h01);
    exc('{own, 8'h03, 8'h00, 8'h00, 8'h00, 8'd33}, 8'h83, 8'h03);
    send('{own + 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 2'd1);
    settle();
    send('{8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h01}, 2'd1);
    settle();
    exp_q.push_back(9'h100);
    send('{own, 8'h06, 8'h00, 8'h01, 8'h12, 8'h34}, 2'd2);
    settle();
    // Partial frame flushed, next byte starts anew
    exp_q.push_back(9'h100);
    send('{own, 8'h03}, 2'd0);
    settle();
    rd(16'h0000, 8'd1);
    // Frozen handler holds its silence count, reply waits for enable
    expect_reply('{own, 8'h03, 8'h02, shadow[1][15:8], shadow[1][7:0]});
    send('{own, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01}, 2'd1);
    ce = 1'b0;
    repeat (2 * SIL) @(negedge core_clk_i);
    check("frozen reply", 0, tx_o.valid);
    ce = 1'b1;
    settle();
    // Early second frame joins the first and fails
    exp_q.push_back(9'h100);
    send('{own, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 2'd1);
    send('{own, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 2'd1);
    settle();
    wrap_up();
  end
endmodule : mrs_frame_bench
`default_nettype wire
